// ==== reset_source_combiner_status_bench.sv ====
// Self-checking bench for the reset source combiner over APB.
// Assumes the design files and rscs_src_model are compiled first.
`timescale 1ns/1ps
`include "rscs_consts.svh"

module reset_source_combiner_status_bench;
  import rscs_pkg::*;
  localparam int POWER_UP_TIMER     = 50;
  localparam int RST_HOLD = `RSCS_TRST_CYC;
  localparam int BOR_HOLD = POWER_UP_TIMER + RST_HOLD;
  localparam int POR_HOLD = `RSCS_TPOR_CYC + BOR_HOLD;
  localparam int VREG_HOLD = `RSCS_TVREG_CYC + RST_HOLD;
  localparam logic [31:0] RCC = `RSCS_RCC_ADDR;
  logic         ref_clk  = 1'b0;
  logic         reset_n  = 1'b0;
  logic         go       = 1'b0;
  logic [3:0]   kind     = 4'h0;
  logic         psel     = 1'b0;
  logic         penable  = 1'b0;
  logic         pwrite   = 1'b0;
  logic [31:0]  paddr    = '0;
  logic [31:0]  pwdata   = '0;
  logic         wfuse    = 1'b0;
  logic         cs_en    = 1'b1;
  logic         reg_en   = 1'b0;
  logic [3:0]   strb     = 4'hf;
  logic [2:0]   osc_fuse = 3'h2;
  logic [2:0]   cur_osc  = 3'h5;
  logic [31:0]  prdata, rd_q;
  logic         pready, pslverr, err_q, msr, wden, keep, pin_n;
  logic [2:0]   osc;
  rscs_src_t    src;
  rscs_power_save_instruction_t ps;
  logic [15:0]  flag_of [2:8] = '{16'h0040, 16'h0010, 16'h0200, 16'h8000, 16'h4000, 16'h4000, 16'h0080};
  int           fail_count = 0;
  int           samples_checked = 0;

  rscs_src_model part_u (.go(go), .kind(kind), .src(src), .external_clear_pin_n(pin_n), .power_save_instruction(ps));

  rscs_reset_combiner #(.POWER_UP_TIMER_CYC(POWER_UP_TIMER)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .src(src), .external_clear_pin_n(pin_n), .power_save_instruction(ps),
    .watchdog_fuse_enable(wfuse), .initial_osc_select_fuse(osc_fuse), .clock_switch_en(cs_en),
    .current_osc_field(cur_osc), .regulator_enabled(reg_en), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .master_system_reset(msr), .system_osc_select(osc),
    .watchdog_enable(wden), .regulator_sleep_keepalive(keep));

  // ----------------------------------------------------------------------
  // Clock, verdict and watchdog
  // ----------------------------------------------------------------------
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run is about 13k cycles; a hang is cut at 40k
  initial begin
    #1000000;
    fail_count++;
    test_done();
  end

  // ----------------------------------------------------------------------
  // APB master and event drivers
  // ----------------------------------------------------------------------
  // Request held until pready is seen high; data and error taken at that edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk("prdata", exp, rd_q);
    chk("pslverr", 32'(e), 32'(err_q));
  endtask

  // Counts the cycles the master reset outlives the last active cycle
  task automatic hold_chk(input int hold);
    int n;
    n = 0;
    #1;
    while (msr === 1'b1 && n < 30000) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    chk("hold_cycles", 32'(hold), 32'(n));
  endtask

  // Kind 15 is a power-on through reset_n, the rest go to the model
  task automatic event_run(input logic [3:0] k, input int hold);
    @(posedge ref_clk);
    if (k == 4'hf) begin
      reset_n <= 1'b0;
    end else begin
      go <= 1'b1;
      kind <= k;
    end
    #1;
    chk("reset_at_source", 32'(hold != 0), 32'(msr));
    @(posedge ref_clk);
    go <= 1'b0;
    reset_n <= 1'b1;
    hold_chk(hold);
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    hold_chk(POR_HOLD);
    rd(RCC, 32'h0003, 1'b0);
    chk("osc_select", 32'(osc_fuse), 32'(osc));
    $display("test power_on done");
    apb(1'b1, RCC, 32'hffff_ffff);
    rd(RCC, 32'h0000_c3ff, 1'b0);
    chk("master_reset", 32'h0, 32'(msr));
    chk("watchdog_enable", 32'h1, 32'(wden));
    chk("keepalive", 32'h1, 32'(keep));
    apb(1'b1, RCC, 32'h0);
    #1;
    chk("keepalive", 32'h0, 32'(keep));
    chk("watchdog_enable", 32'h0, 32'(wden));
    @(posedge ref_clk);
    wfuse <= 1'b1;
    #1;
    chk("watchdog_enable", 32'h1, 32'(wden));
    @(posedge ref_clk);
    wfuse <= 1'b0;
    rd(32'h8, 32'h0, 1'b1);
    rd(`RSCS_SEQ_STAT_ADDR, 32'h0000_0002, 1'b0);
    // Upper byte lane only: regulator bit lands, watchdog bit does not
    @(posedge ref_clk);
    strb <= 4'h2;
    apb(1'b1, RCC, 32'hffff_ffff);
    strb <= 4'hf;
    rd(RCC, 32'h0000_c300, 1'b0);
    chk("keepalive", 32'h1, 32'(keep));
    chk("watchdog_enable", 32'h0, 32'(wden));
    $display("test registers done");
    // Software clears flags before each event so each read shows one cause
    for (int k = 2; k <= 8; k++) begin
      apb(1'b1, RCC, 32'h0);
      event_run(4'(k), RST_HOLD);
      rd(RCC, 32'(flag_of[k]), 1'b0);
      chk("osc_select", 32'(cur_osc), 32'(osc));
    end
    $display("test short sources done");
    event_run(4'h1, BOR_HOLD);
    rd(RCC, 32'h0082, 1'b0);
    chk("osc_select", 32'(osc_fuse), 32'(osc));
    event_run(4'h8, RST_HOLD);
    @(posedge ref_clk);
    cs_en <= 1'b0;
    event_run(4'h3, RST_HOLD);
    chk("osc_select", 32'(osc_fuse), 32'(osc));
    rd(RCC, 32'h0092, 1'b0);
    event_run(4'h9, 0);
    rd(RCC, 32'h008a, 1'b0);
    event_run(4'ha, 0);
    rd(RCC, 32'h008e, 1'b0);
    $display("test brown_out and power_save done");
    event_run(4'hf, POR_HOLD);
    rd(RCC, 32'h0003, 1'b0);
    // Power-on from the supervisor line must clear flags set by software
    apb(1'b1, RCC, 32'hffff_ffff);
    event_run(4'h0, POR_HOLD);
    rd(RCC, 32'h0003, 1'b0);
    chk("osc_select", 32'(osc_fuse), 32'(osc));
    // Regulator start-up replaces the power-up timer in the brown-out hold
    @(posedge ref_clk);
    reg_en <= 1'b1;
    event_run(4'h1, VREG_HOLD);
    $display("test second power_on done");
    test_done();
  end
endmodule

// ==== rscs_consts.svh ====
// Constants for the reset source combiner: register map, flag positions,
// reset values and reset-sequence timing.
// Assumes the 40 MHz ref_clk and a 32-bit APB register bus.
`ifndef RSCS_CONSTS_SVH
`define RSCS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define RSCS_RCC_ADDR       32'h0000_0000
`define RSCS_SEQ_STAT_ADDR  32'h0000_0004

// ----------------------------------------------------------------------
// Field positions of reset_cause_control
// ----------------------------------------------------------------------
`define RSCS_TRAP_BIT       15
`define RSCS_BADOP_BIT      14
`define RSCS_CFGMIS_BIT     9
`define RSCS_VREG_BIT       8
`define RSCS_PINRST_BIT     7
`define RSCS_SOFTRST_BIT    6
`define RSCS_WDTEN_BIT      5
`define RSCS_WATCHDOG_TIMEOUT_FLAG_BIT       4
`define RSCS_SLEEP_BIT      3
`define RSCS_IDLE_BIT       2
`define RSCS_BOR_BIT        1
`define RSCS_POR_BIT        0

// Bits 13..10 are not implemented and read as zero
`define RSCS_RCC_IMPL_MASK  16'hc3ff
// Value taken on power-on reset: only brown-out and power-on flags set
`define RSCS_RCC_POR_VAL    16'h0003
`define RSCS_OSC_RST_VAL    3'h0

// ----------------------------------------------------------------------
// Reset timing
// ----------------------------------------------------------------------
`define RSCS_CLK_MHZ        40
`define RSCS_TPOR_US        10
`define RSCS_TVREG_US       10
`define RSCS_TRST_US        20
`define RSCS_TPWRT_MS       64
`define RSCS_TPOR_CYC       (`RSCS_TPOR_US * `RSCS_CLK_MHZ)
`define RSCS_TVREG_CYC      (`RSCS_TVREG_US * `RSCS_CLK_MHZ)
`define RSCS_TRST_CYC       (`RSCS_TRST_US * `RSCS_CLK_MHZ)
`define RSCS_TPWRT_CYC      (`RSCS_TPWRT_MS * 1000 * `RSCS_CLK_MHZ)
`define RSCS_CNT_W          22

`endif

// ==== rscs_pkg.sv ====
// Types shared by the reset source combiner and its surroundings.
// Assumes rscs_consts.svh supplies all numeric constants.
`include "rscs_consts.svh"

package rscs_pkg;

  // Reset requests from the core and supervisors, all active high levels
  typedef struct packed {
    logic power_on;
    logic brown_out;
    logic reset_instr;
    logic wdt_timeout;
    logic cfg_mismatch;
    logic trap_conflict;
    logic illegal_opcode;
    logic uninit_wreg_reset;
  } rscs_src_t;

  // Power-saving instruction events, one-cycle pulses
  typedef struct packed {
    logic enter_sleep;
    logic enter_idle;
  } rscs_power_save_instruction_t;

  // Reset sequencing phases
  typedef enum logic [1:0] {
    RSCS_RUN,
    RSCS_POR_WAIT,
    RSCS_STARTUP_WAIT,
    RSCS_RST_WAIT
  } rscs_state_t;

endpackage

// ==== rscs_reset_combiner.sv ====
// Reset source combiner: merges all reset sources into the master system
// reset, records the cause in reset_cause_control and picks the clock.
// Assumes all inputs are synchronous to ref_clk and an APB master.
`timescale 1ns/1ps
`include "rscs_consts.svh"

module rscs_reset_combiner
  #(
    parameter int unsigned POWER_UP_TIMER_CYC = `RSCS_TPWRT_CYC
  )
  (
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire rscs_pkg::rscs_src_t src,
    input  wire logic                external_clear_pin_n,
    input  wire rscs_pkg::rscs_power_save_instruction_t power_save_instruction,
    input  wire logic                watchdog_fuse_enable,
    input  wire logic [2:0]          initial_osc_select_fuse,
    input  wire logic                clock_switch_en,
    input  wire logic [2:0]          current_osc_field,
    input  wire logic                regulator_enabled,
    input  wire logic [31:0]         paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic                     master_system_reset,
    output logic [2:0]               system_osc_select,
    output logic                     watchdog_enable,
    output logic                     regulator_sleep_keepalive
  );

  import rscs_pkg::*;

  localparam logic [`RSCS_CNT_W-1:0] TPOR_CYC  = `RSCS_CNT_W'(`RSCS_TPOR_CYC);
  localparam logic [`RSCS_CNT_W-1:0] TVREG_CYC = `RSCS_CNT_W'(`RSCS_TVREG_CYC);
  localparam logic [`RSCS_CNT_W-1:0] TRST_CYC  = `RSCS_CNT_W'(`RSCS_TRST_CYC);
  localparam logic [`RSCS_CNT_W-1:0] TPWRT_CYC = `RSCS_CNT_W'(POWER_UP_TIMER_CYC);
  localparam logic [`RSCS_CNT_W-1:0] CNT_ONE   = `RSCS_CNT_W'(1);

  // ----------------------------------------------------------------------
  // Source decoding
  // ----------------------------------------------------------------------
  logic por_evt;
  logic bor_evt;
  logic pin_evt;
  logic short_src;
  logic any_src;

  // The block's own reset is treated as a power-on event
  assign por_evt   = !reset_n || src.power_on;
  assign bor_evt   = src.brown_out;
  assign pin_evt   = !external_clear_pin_n;
  // Sources that only need the internal state reset time
  assign short_src = pin_evt || src.reset_instr || src.wdt_timeout || src.cfg_mismatch
                     || src.trap_conflict || src.illegal_opcode || src.uninit_wreg_reset;
  assign any_src   = por_evt || bor_evt || short_src;

  // ----------------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------------
  rscs_state_t               fsm_q;
  rscs_state_t               fsm_d;
  logic [`RSCS_CNT_W-1:0]    cnt_q;
  logic [`RSCS_CNT_W-1:0]    cnt_d;
  logic [`RSCS_CNT_W-1:0]    startup_cyc;

  // Regulator start-up is short; without it the power-up timer must run
  assign startup_cyc = regulator_enabled ? TVREG_CYC : TPWRT_CYC;

  // A weaker source never shortens a longer sequence already under way
  always_comb begin
    fsm_d = fsm_q;
    cnt_d = cnt_q;
    if (por_evt) begin
      fsm_d = RSCS_POR_WAIT;
      cnt_d = TPOR_CYC;
    end else if (bor_evt) begin
      if (fsm_q != RSCS_POR_WAIT) begin
        fsm_d = RSCS_STARTUP_WAIT;
        cnt_d = startup_cyc;
      end
    end else if (short_src) begin
      if (fsm_q == RSCS_RUN || fsm_q == RSCS_RST_WAIT) begin
        fsm_d = RSCS_RST_WAIT;
        cnt_d = TRST_CYC;
      end
    end else begin
      case (fsm_q)
        RSCS_RUN: begin
          cnt_d = '0;
        end
        RSCS_POR_WAIT: begin
          if (cnt_q <= CNT_ONE) begin
            fsm_d = RSCS_STARTUP_WAIT;
            cnt_d = startup_cyc;
          end else begin
            cnt_d = cnt_q - CNT_ONE;
          end
        end
        RSCS_STARTUP_WAIT: begin
          if (cnt_q <= CNT_ONE) begin
            fsm_d = RSCS_RST_WAIT;
            cnt_d = TRST_CYC;
          end else begin
            cnt_d = cnt_q - CNT_ONE;
          end
        end
        RSCS_RST_WAIT: begin
          if (cnt_q <= CNT_ONE) begin
            fsm_d = RSCS_RUN;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q - CNT_ONE;
          end
        end
        default: begin
          fsm_d = RSCS_POR_WAIT;
          cnt_d = TPOR_CYC;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    fsm_q <= fsm_d;
    cnt_q <= cnt_d;
  end

  // Assertion is combinational so the core stops at once; release only
  // comes from the clocked sequencer, so it can never be metastable
  assign master_system_reset = any_src || (fsm_q != RSCS_RUN);

  // ----------------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------------
  logic [2:0] osc_q;
  logic [2:0] osc_d;

  // Sampled while a source is active; the last sample wins at release
  always_comb begin
    osc_d = osc_q;
    if (por_evt || bor_evt) begin
      osc_d = initial_osc_select_fuse;
    end else if (short_src) begin
      if (clock_switch_en) begin
        osc_d = current_osc_field;
      end else begin
        osc_d = initial_osc_select_fuse;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    osc_q <= osc_d;
  end

  assign system_osc_select = osc_q;

  // ----------------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------------
  logic        setup_ph;
  logic        access_ph;
  logic        hit_rcc;
  logic        hit_stat;
  logic        wr_rcc;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [15:0] rcc_q;
  logic [15:0] rcc_d;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign hit_rcc   = (paddr == `RSCS_RCC_ADDR);
  assign hit_stat  = (paddr == `RSCS_SEQ_STAT_ADDR);
  assign wr_rcc    = access_ph && pwrite && hit_rcc;
  assign pready    = 1'b1;
  assign pslverr   = access_ph && !(hit_rcc || hit_stat);

  // Read data is captured in the setup phase so it comes from a flop;
  // cleared under reset so the read bus never shows an unknown word
  always_comb begin
    prdata_d = prdata_q;
    if (!reset_n) begin
      prdata_d = 32'h0000_0000;
    end else if (setup_ph) begin
      if (hit_rcc) begin
        prdata_d = {16'h0000, rcc_q};
      end else if (hit_stat) begin
        prdata_d = {28'h0000000, watchdog_enable, osc_q};
      end else begin
        prdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    prdata_q <= prdata_d;
  end

  assign prdata = prdata_q;

  // ----------------------------------------------------------------------
  // reset_cause_control
  // ----------------------------------------------------------------------
  // Order matters: software write, then hardware clear, then hardware set, then power-on load,
  // so an event in the same cycle as a clear other than power-on is never lost
  always_comb begin
    rcc_d = rcc_q;
    if (wr_rcc) begin
      if (pstrb[0]) begin
        rcc_d[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        rcc_d[15:8] = pwdata[15:8];
      end
    end
    if (power_save_instruction.enter_sleep || power_save_instruction.enter_idle) begin
      rcc_d[`RSCS_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
    end
    if (src.trap_conflict) begin
      rcc_d[`RSCS_TRAP_BIT] = 1'b1;
    end
    if (src.illegal_opcode || src.uninit_wreg_reset) begin
      rcc_d[`RSCS_BADOP_BIT] = 1'b1;
    end
    if (src.cfg_mismatch) begin
      rcc_d[`RSCS_CFGMIS_BIT] = 1'b1;
    end
    if (pin_evt) begin
      rcc_d[`RSCS_PINRST_BIT] = 1'b1;
    end
    if (src.reset_instr) begin
      rcc_d[`RSCS_SOFTRST_BIT] = 1'b1;
    end
    if (src.wdt_timeout) begin
      rcc_d[`RSCS_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
    end
    if (power_save_instruction.enter_sleep) begin
      rcc_d[`RSCS_SLEEP_BIT] = 1'b1;
    end
    if (power_save_instruction.enter_idle) begin
      rcc_d[`RSCS_IDLE_BIT] = 1'b1;
    end
    if (bor_evt) begin
      rcc_d[`RSCS_BOR_BIT] = 1'b1;
    end
    // Power-on sets the brown-out and power-on flags and clears all others and the controls; sleep or idle entry clears only the time-out flag
    if (por_evt) begin
      rcc_d = `RSCS_RCC_POR_VAL;
    end
    rcc_d = rcc_d & `RSCS_RCC_IMPL_MASK;
  end

  // Not reset by non-power-on resets, so the cause survives them
  always_ff @(posedge ref_clk) begin
    rcc_q <= rcc_d;
  end

  // Fuse at one overrides the software enable
  assign watchdog_enable           = watchdog_fuse_enable || rcc_q[`RSCS_WDTEN_BIT];
  assign regulator_sleep_keepalive = rcc_q[`RSCS_VREG_BIT];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  src_reset_a: assert property (any_src |-> master_system_reset)
    else $error("reset source active without master reset");

  trap_flag_a: assert property (src.trap_conflict && !por_evt |=> rcc_q[`RSCS_TRAP_BIT])
    else $error("trap conflict did not set its flag");

  unimpl_zero_a: assert property (rcc_q[13:10] == 4'h0 && prdata[13:10] == 4'h0)
    else $error("unimplemented bits not zero");

  por_value_a: assert property (src.power_on |=> rcc_q == `RSCS_RCC_POR_VAL)
    else $error("power-on did not load flag value");

  wdt_fuse_a: assert property (watchdog_fuse_enable |-> watchdog_enable)
    else $error("watchdog fuse did not force enable");

  rst_release_a: assert property ($fell(master_system_reset) |->
      $past(fsm_q) == RSCS_RST_WAIT && $past(cnt_q) == CNT_ONE)
    else $error("master reset released early");

  trst_load_a: assert property (short_src && !por_evt && !bor_evt && fsm_q == RSCS_RUN
      |=> fsm_q == RSCS_RST_WAIT && cnt_q == TRST_CYC)
    else $error("short reset did not load hold time");

  por_chain_a: assert property (fsm_q == RSCS_POR_WAIT && cnt_q == CNT_ONE && !any_src
      |=> fsm_q == RSCS_STARTUP_WAIT && cnt_q == $past(startup_cyc))
    else $error("power-on delay not followed by start-up delay");

  watchdog_timeout_flag_clear_a: assert property (power_save_instruction.enter_sleep && !src.wdt_timeout && !wr_rcc && !por_evt
      |=> !rcc_q[`RSCS_WATCHDOG_TIMEOUT_FLAG_BIT] && rcc_q[`RSCS_SLEEP_BIT])
    else $error("sleep entry flag handling wrong");

  osc_keep_a: assert property (clock_switch_en && short_src && !por_evt && !bor_evt
      |=> system_osc_select == $past(current_osc_field))
    else $error("short reset did not keep current oscillator");

  osc_fuse_a: assert property (!clock_switch_en && any_src
      |=> system_osc_select == $past(initial_osc_select_fuse))
    else $error("oscillator fuse not taken");

  sw_no_reset_a: assert property (wr_rcc && !any_src && fsm_q == RSCS_RUN
      |=> !master_system_reset)
    else $error("software write caused a reset");

  // Checked against the written word, not the register, so a broken
  // write path or a stuck output is caught
  reg_keep_a: assert property (wr_rcc && pstrb[1] && !por_evt
      |=> regulator_sleep_keepalive == $past(pwdata[`RSCS_VREG_BIT]))
    else $error("regulator control not taken from write");

  // Each cause flag follows its own source one cycle later
  badop_flag_a: assert property (src.illegal_opcode && !por_evt |=> rcc_q[`RSCS_BADOP_BIT])
    else $error("illegal opcode did not set its flag");

  uwr_flag_a: assert property (src.uninit_wreg_reset && !por_evt |=> rcc_q[`RSCS_BADOP_BIT])
    else $error("uninitialised register did not set its flag");

  cfg_flag_a: assert property (src.cfg_mismatch && !por_evt |=> rcc_q[`RSCS_CFGMIS_BIT])
    else $error("configuration mismatch did not set its flag");

  pin_flag_a: assert property (pin_evt && !por_evt |=> rcc_q[`RSCS_PINRST_BIT])
    else $error("pin reset did not set its flag");

  soft_flag_a: assert property (src.reset_instr && !por_evt |=> rcc_q[`RSCS_SOFTRST_BIT])
    else $error("reset instruction did not set its flag");

  watchdog_timeout_flag_flag_a: assert property (src.wdt_timeout && !por_evt |=> rcc_q[`RSCS_WATCHDOG_TIMEOUT_FLAG_BIT])
    else $error("watchdog time-out did not set its flag");

  idle_flag_a: assert property (power_save_instruction.enter_idle && !por_evt |=> rcc_q[`RSCS_IDLE_BIT])
    else $error("idle entry did not set its flag");

  bor_flag_a: assert property (bor_evt && !por_evt |=> rcc_q[`RSCS_BOR_BIT])
    else $error("brown-out did not set its flag");

  // No cause flag but the time-out flag may drop without power-on or a write
  flag_keep_a: assert property (!por_evt && !wr_rcc
      |=> ($past(rcc_q) & ~rcc_q & 16'hc2cf) == 16'h0000)
    else $error("cause flag cleared by hardware");

endmodule

// ==== rscs_src_model.sv ====
// Far-side model: reset sources, master clear pin and power-save events.
// Assumes the bench raises go for exactly one ref_clk cycle per event.
`timescale 1ns/1ps

module rscs_src_model (
  input  wire logic                   go,
  input  wire logic [3:0]             kind,
  output rscs_pkg::rscs_src_t         src,
  output logic                        external_clear_pin_n,
  output rscs_pkg::rscs_power_save_instruction_t      power_save_instruction
);
  import rscs_pkg::*;

  // ----------------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------------
  // Lines rest at their inactive level outside an event, so a stale
  // level can never pose as a second reset request
  always_comb begin
    src = '0;
    if (go && kind < 4'h8) begin
      src = rscs_src_t'(8'h80 >> kind);
    end
    external_clear_pin_n = !(go && kind == 4'h8);
    power_save_instruction.enter_sleep   = go && kind == 4'h9;
    power_save_instruction.enter_idle    = go && kind == 4'ha;
  end
endmodule
